// File: hw/pbs_port.sv
// pipelined burst memory port top level
//
// What this block does
// RQ1: capture address when a strobe is low and all three selects active.
// RQ2: load two low address bits into burst counter on capture.
// RQ3: counter holds first address and steps through four-beat burst.
// RQ4: advance counter on each edge with burst step low in a burst.
// RQ5: lane select writes its lane only when qualified by lane qualify.
// RQ6: controller drives lane qualify low for selective lane writes.
// RQ7: global write low writes every lane, ignoring lane controls.
// RQ8: three selects: first and third active low, second active high.
// RQ9: selects sampled only on cycles loading a new external address.
// RQ10: processor strobe ignored while first select is high.
// RQ11: both strobes low: only the processor strobe is acted upon.
// RQ12: output enable low drives data pins; high makes them inputs.
// RQ13: first read cycle after deselect keeps outputs off regardless of enable.
// RQ14: read data appears one clock after its address edge, registered.
// RQ15: input data captured into a data register on the rising edge.
// RQ16: data outputs come from registers updated on rising edge.
// RQ17: single read starts on strobe, selects active, both write inputs high.
// RQ18: back-to-back single reads accepted, one per clock.
// RQ19: deselect with a strobe turns outputs off at once.
// RQ20: first cycle of processor-strobe write ignores write controls and step.
// RQ21: order strap low linear, high interleaved; kept static.
// RQ22: sleep high enters low power, data kept; low for normal use.
// RQ23: linear order adds one modulo four from start.
// RQ24: interleaved order xors start with count 00,01,10,11.
// RQ25: processor-strobe write takes two clocks; second edge controls decide.
// RQ26: processor strobe always starts a read, whatever the write controls.
// RQ27: no strobe and step high keep address and continue the access.
`timescale 1ns/1ps
`include "pbs_map.svh"
module pbs_port
  import pbs_pkg::*;
(
  // clock and reset
  input  wire logic                   i_clock,
  input  wire logic                   i_arst_n,
  // address and strobes
  input  wire logic [`PBS_ADDR_W-1:0] i_addr,
  input  wire logic                   i_cpu_addr_strobe_n,
  input  wire logic                   i_ctrl_addr_strobe_n,
  input  wire logic                   i_burst_step_n,
  // chip selects
  input  wire logic                   i_select_low_first,
  input  wire logic                   i_select_high_second,
  input  wire logic                   i_select_low_third,
  // write controls
  input  wire logic                   i_all_lanes_write_n,
  input  wire logic                   i_lane_write_qualify_n,
  input  wire logic [`PBS_LANES-1:0]  i_lane_write_select_n,
  // asynchronous controls
  input  wire logic                   i_output_enable_n,
  input  wire logic                   i_sleep_request,
  input  wire logic                   i_burst_order,
  // data pins
  input  wire logic [`PBS_DATA_W-1:0] i_data,
  output logic      [`PBS_DATA_W-1:0] o_data,
  output logic                        o_data_oe,
  output logic                        o_sleeping
);
  // input synchronisers for asynchronous pins
  logic [2:0] oe_sync_q;
  logic [2:0] zz_sync_q;
  logic [2:0] mode_sync_q;
  logic       oe_n_q;
  logic       zz_q;
  logic       linear_q;

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      oe_sync_q   <= 3'h7;
      zz_sync_q   <= 3'h0;
      mode_sync_q <= 3'h7;
    end else begin
      oe_sync_q   <= {oe_sync_q[1:0], i_output_enable_n};
      zz_sync_q   <= {zz_sync_q[1:0], i_sleep_request};
      mode_sync_q <= {mode_sync_q[1:0], i_burst_order};
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      oe_n_q   <= 1'b1;
      zz_q     <= 1'b0;
      linear_q <= 1'b0;
    end else begin
      if (oe_sync_q[1] == oe_sync_q[2]) begin
        oe_n_q <= oe_sync_q[2];
      end
      if (zz_sync_q[1] == zz_sync_q[2]) begin
        zz_q <= zz_sync_q[2];
      end
      if (mode_sync_q[1] == mode_sync_q[2]) begin
        linear_q <= (mode_sync_q[2] == `PBS_ORDER_LIN); // [RQ21]
      end
    end
  end

  // sleep entry and exit take a fixed number of cycles
  logic [1:0] zz_cnt_q;
  logic       sleep_q;
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      zz_cnt_q <= 2'h0;
      sleep_q  <= 1'b0;
    end else if (zz_q != sleep_q) begin
      if (zz_cnt_q == 2'(`PBS_ZZ_CYCLES - 1)) begin
        sleep_q  <= zz_q; // [RQ22]
        zz_cnt_q <= 2'h0;
      end else begin
        zz_cnt_q <= zz_cnt_q + 2'h1;
      end
    end else begin
      zz_cnt_q <= 2'h0;
    end
  end

  // decode of the sampled pins
  logic selected;
  logic cpu_go;
  logic ctrl_go;
  logic strobe_go;
  logic any_write;
  logic [`PBS_LANES-1:0] lanes;

  assign selected  = !i_select_low_first && i_select_high_second
                     && !i_select_low_third;                       // [RQ8]
  // processor strobe counts only with first select low
  assign cpu_go    = !i_cpu_addr_strobe_n && !i_select_low_first;   // [RQ10]
  // controller strobe is disregarded when the processor strobe acts
  assign ctrl_go   = !i_ctrl_addr_strobe_n && !cpu_go;             // [RQ11]
  assign strobe_go = (cpu_go || ctrl_go) && !sleep_q;
  always_comb begin
    if (!i_all_lanes_write_n) begin
      lanes = '1;                                                   // [RQ7]
    end else if (!i_lane_write_qualify_n) begin
      lanes = ~i_lane_write_select_n;                               // [RQ5] [RQ6]
    end else begin
      lanes = '0;
    end
  end
  assign any_write = |lanes;

  // access state
  pbs_op_t                op_q;
  logic                   first_q;
  logic [`PBS_ADDR_W-1:0] addr_q;
  logic                   desel_q;
  pbs_burst_if            burst ();

  assign burst.linear = linear_q;
  assign burst.start  = i_addr[1:0];
  assign burst.load   = strobe_go && selected;                      // [RQ2] [RQ9]
  // no step while loading, none in the first processor write cycle
  assign burst.step   = !strobe_go && !i_burst_step_n && op_q != PBS_IDLE
                        && !sleep_q;                                // [RQ4] [RQ20] [RQ27]

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      addr_q <= '0;
    end else if (burst.load) begin
      addr_q <= i_addr;                                             // [RQ1]
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      op_q    <= PBS_IDLE;
      first_q <= 1'b0;
      desel_q <= 1'b1;
    end else if (strobe_go) begin
      first_q <= 1'b0;
      if (!selected) begin
        op_q    <= PBS_IDLE;                                        // [RQ19]
        desel_q <= 1'b1;
      end else begin
        desel_q <= 1'b0;
        first_q <= desel_q;                                         // [RQ13]
        if (cpu_go || !any_write) begin
          op_q <= PBS_READ;                                         // [RQ17] [RQ26] [RQ18]
        end else begin
          op_q <= PBS_WRITE;
        end
      end
    end else begin
      first_q <= 1'b0;
      if (op_q != PBS_IDLE) begin
        // continued cycles take the current write controls [RQ25]
        op_q <= any_write ? PBS_WRITE : PBS_READ;
      end
    end
  end

  // memory access at the current burst address
  logic [`PBS_ADDR_W-1:0] cur_addr;
  logic [`PBS_LANES-1:0]  we;
  logic [`PBS_DATA_W-1:0] rdata;
  logic [`PBS_DATA_W-1:0] din_q;
  logic                   ctrl_wr_now;

  // a controller-strobe write is done in its own cycle
  assign ctrl_wr_now = ctrl_go && selected && !sleep_q && any_write;
  assign cur_addr = ctrl_wr_now ? i_addr
                    : {addr_q[`PBS_ADDR_W-1:2], burst.pos};
  assign we = ctrl_wr_now ? lanes
              : ((!strobe_go && op_q != PBS_IDLE && !sleep_q) ? lanes : '0); // [RQ25]

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      din_q <= '0;
    end else begin
      din_q <= i_data;                                              // [RQ15]
    end
  end

  pbs_mem_array u_mem (
    .i_clock  (i_clock),
    .i_addr   (cur_addr),
    .i_lane_we(we),
    .i_wdata  (i_data),
    .o_rdata  (rdata)
  );

  pbs_burst_counter u_cnt (
    .i_clock (i_clock),
    .i_arst_n(i_arst_n),
    .bus     (burst)
  );

  // output registers
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_data <= '0;
    end else begin
      o_data <= rdata;                                              // [RQ14] [RQ16]
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_data_oe <= 1'b0;
    end else begin
      // drive only for a read past its first cycle after deselect
      o_data_oe <= !oe_n_q && op_q == PBS_READ && !first_q && !sleep_q
                   && !(strobe_go && !selected) && !any_write;      // [RQ12] [RQ13] [RQ19]
    end
  end

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_sleeping <= 1'b0;
    end else begin
      o_sleeping <= sleep_q;                                        // [RQ22]
    end
  end
endmodule : pbs_port

// File: hw/pbs_map.svh
// constants for the pipelined burst memory port
`ifndef PBS_MAP_SVH
`define PBS_MAP_SVH
`define PBS_ADDR_W      8
`define PBS_DATA_W      36
`define PBS_LANES       4
`define PBS_LANE_W      9
`define PBS_DEPTH       256
`define PBS_ZZ_CYCLES   2
`define PBS_ORDER_LIN   1'b0
`endif

// File: hw/pbs_pkg.sv
// types for the pipelined burst memory port
package pbs_pkg;
  typedef enum logic [1:0] {
    PBS_IDLE,
    PBS_READ,
    PBS_WRITE
  } pbs_op_t;
endpackage : pbs_pkg

// File: hw/pbs_burst_if.sv
// carries burst counter controls and position between modules
`timescale 1ns/1ps
`include "pbs_map.svh"
interface pbs_burst_if;
  logic       load;
  logic [1:0] start;
  logic       step;
  logic       linear;
  logic [1:0] pos;
  modport ctl (output load, output start, output step, output linear, input pos);
  modport cnt (input load, input start, input step, input linear, output pos);
endinterface : pbs_burst_if

// File: hw/pbs_burst_counter.sv
// two-bit wraparound burst counter, linear or interleaved
`timescale 1ns/1ps
`include "pbs_map.svh"
module pbs_burst_counter
  import pbs_pkg::*;
(
  // clock and reset
  input  wire logic i_clock,
  input  wire logic i_arst_n,
  // control
  pbs_burst_if.cnt  bus
);
  logic [1:0] start_q;
  logic [1:0] cnt_q;

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      start_q <= 2'h0;
      cnt_q   <= 2'h0;
    end else if (bus.load) begin
      start_q <= bus.start;   // [RQ2]
      cnt_q   <= 2'h0;
    end else if (bus.step) begin
      cnt_q   <= cnt_q + 2'h1; // [RQ3] [RQ4]
    end
  end

  // linear adds the count, interleaved xors it
  assign bus.pos = bus.linear ? (start_q + cnt_q) : (start_q ^ cnt_q); // [RQ23] [RQ24]
endmodule : pbs_burst_counter

// File: hw/pbs_mem_array.sv
// storage array with per-lane write enables
`timescale 1ns/1ps
`include "pbs_map.svh"
module pbs_mem_array
  import pbs_pkg::*;
(
  // clock
  input  wire logic                     i_clock,
  // access
  input  wire logic [`PBS_ADDR_W-1:0]   i_addr,
  input  wire logic [`PBS_LANES-1:0]    i_lane_we,
  input  wire logic [`PBS_DATA_W-1:0]   i_wdata,
  output logic      [`PBS_DATA_W-1:0]   o_rdata
);
  // each lane owns its own storage so that one process drives it
  genvar g;
  generate
    for (g = 0; g < `PBS_LANES; g++) begin : g_lane
      logic [`PBS_LANE_W-1:0] lane_q [`PBS_DEPTH];
      always_ff @(posedge i_clock) begin
        if (i_lane_we[g]) begin
          lane_q[i_addr] <= i_wdata[g*`PBS_LANE_W +: `PBS_LANE_W];
        end
      end
      assign o_rdata[g*`PBS_LANE_W +: `PBS_LANE_W] = lane_q[i_addr];
    end
  endgenerate
endmodule : pbs_mem_array

// File: verification/pbs_host_model.sv
// controller-side model that resolves the shared data pins
`timescale 1ns/1ps
`include "pbs_map.svh"
module pbs_host_model (
  // clock
  input  wire logic                   i_clock,
  // controller side
  input  wire logic                   i_drive,
  input  wire logic [`PBS_DATA_W-1:0] i_wdata,
  // device side
  input  wire logic [`PBS_DATA_W-1:0] i_dev_data,
  input  wire logic                   i_dev_oe,
  output logic      [`PBS_DATA_W-1:0] o_bus
);
  logic [`PBS_DATA_W-1:0] last_q = '0;
  always @(posedge i_clock) begin
    last_q <= o_bus;
  end
  // released pins show the inverse of the last level, never a held copy
  always_comb begin
    if (i_dev_oe) begin
      o_bus = i_dev_data;
    end else if (i_drive) begin
      o_bus = i_wdata;
    end else begin
      o_bus = ~last_q;
    end
  end
endmodule : pbs_host_model

// File: verification/pbs_port_monitor.sv
// pin-level assertions for the burst memory port
`timescale 1ns/1ps
`include "pbs_map.svh"
module pbs_port_monitor (
  // clock and reset
  input wire logic                   i_clock,
  input wire logic                   i_arst_n,
  // strobes and selects
  input wire logic                   i_cpu_addr_strobe_n,
  input wire logic                   i_ctrl_addr_strobe_n,
  input wire logic                   i_burst_step_n,
  input wire logic                   i_select_low_first,
  input wire logic                   i_select_high_second,
  input wire logic                   i_select_low_third,
  // write and asynchronous controls
  input wire logic                   i_all_lanes_write_n,
  input wire logic                   i_lane_write_qualify_n,
  input wire logic                   i_output_enable_n,
  input wire logic                   i_sleep_request,
  // outputs
  input wire logic [`PBS_DATA_W-1:0] o_data,
  input wire logic                   o_data_oe,
  input wire logic                   o_sleeping
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_arst_n);
  logic sel;
  logic wr_off;
  assign sel    = !i_select_low_first && i_select_high_second && !i_select_low_third;
  assign wr_off = i_all_lanes_write_n && i_lane_write_qualify_n;
  sequence desel_s;
    !i_ctrl_addr_strobe_n && i_cpu_addr_strobe_n && !i_select_high_second;
  endsequence
  sequence ctrl_wr_s;
    !i_ctrl_addr_strobe_n && i_cpu_addr_strobe_n && sel && !i_all_lanes_write_n;
  endsequence
  sequence read_s;
    !i_cpu_addr_strobe_n && sel && wr_off && !i_output_enable_n && !i_sleep_request;
  endsequence
  sequence quiet_s;
    i_cpu_addr_strobe_n && i_ctrl_addr_strobe_n && i_burst_step_n && wr_off
      && !i_sleep_request && !o_sleeping;
  endsequence
  chk_desel_off: assert property (desel_s |=> !o_data_oe)
    else $error("pins driven after deselect");
  chk_write_off: assert property (ctrl_wr_s |=> !o_data_oe)
    else $error("pins driven during write");
  chk_first_read: assert property (desel_s ##1 read_s |=> !o_data_oe)
    else $error("pins driven on first read after deselect");
  chk_read_drive: assert property (read_s [*6] |=> o_data_oe)
    else $error("pins not driven during read stream");
  chk_oe_high: assert property (i_output_enable_n [*6] |=> !o_data_oe)
    else $error("pins driven with output enable high");
  chk_sleep_enter: assert property ($rose(i_sleep_request) |-> ##[1:10] o_sleeping)
    else $error("sleep not entered in time");
  chk_sleep_quiet: assert property (o_sleeping |-> !o_data_oe)
    else $error("pins driven in sleep");
  chk_idle_hold: assert property (quiet_s [*3] |=> $stable(o_data))
    else $error("read data moved without access");
endmodule : pbs_port_monitor
bind pbs_port pbs_port_monitor u_pbs_port_monitor (
  .i_clock, .i_arst_n, .i_cpu_addr_strobe_n, .i_ctrl_addr_strobe_n, .i_burst_step_n,
  .i_select_low_first, .i_select_high_second, .i_select_low_third, .i_all_lanes_write_n,
  .i_lane_write_qualify_n, .i_output_enable_n, .i_sleep_request, .o_data, .o_data_oe,
  .o_sleeping
);

// File: verification/pipelined_burst_sram_port_tb_top.sv
// self-checking bench for the burst memory port
`timescale 1ns/1ps
`include "pbs_map.svh"
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin failures++; $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module pipelined_burst_sram_port_tb_top;
  import pbs_pkg::*;
  typedef struct {
    logic [7:0]  a;
    logic [3:0]  c;
    logic [35:0] d;
    logic [35:0] e;
  } pbs_row_t;
  logic i_clock, i_arst_n, i_cpu_addr_strobe_n, i_ctrl_addr_strobe_n, i_burst_step_n;
  logic i_select_low_first, i_select_high_second, i_select_low_third, i_all_lanes_write_n;
  logic i_lane_write_qualify_n, i_output_enable_n, i_sleep_request, i_burst_order;
  logic o_data_oe, o_sleeping, drive;
  logic [`PBS_ADDR_W-1:0] i_addr;
  logic [`PBS_LANES-1:0]  i_lane_write_select_n;
  logic [`PBS_DATA_W-1:0] i_data, o_data, wdata;
  logic [`PBS_DATA_W-1:0] mem_m [`PBS_DEPTH];
  int                     failures, checked;
  // rc[5:0] is {global write, qualify, lane selects [3:0]}, all active low
  logic [7:0] rc [8] = '{8'h0F, 8'h0F, 8'h0F, 8'h0F, 8'h2A, 8'h30, 8'h05, 8'h10};
  pbs_row_t rows [8] = '{
    '{8'h20, 4'h0, 36'h1_1111_1111, 36'h1_1111_1111},
    '{8'h21, 4'h0, 36'h2_2222_2222, 36'h2_2222_2222},
    '{8'h22, 4'h0, 36'h3_3333_3333, 36'h3_3333_3333},
    '{8'h23, 4'h0, 36'h4_4444_4444, 36'h4_4444_4444},
    '{8'h21, 4'h0, 36'hF_FFFF_FFFF, 36'h2_27FE_23FF},
    '{8'h22, 4'h0, 36'h0_0000_0000, 36'h3_3333_3333},
    '{8'h23, 4'h0, 36'h5_A5A5_A5A5, 36'h5_A5A5_A5A5},
    '{8'h20, 4'h0, 36'h9_8765_4321, 36'h9_8765_4321}};

  pbs_port u_pbs_port (.i_clock, .i_arst_n, .i_addr, .i_cpu_addr_strobe_n,
    .i_ctrl_addr_strobe_n, .i_burst_step_n, .i_select_low_first, .i_select_high_second,
    .i_select_low_third, .i_all_lanes_write_n, .i_lane_write_qualify_n,
    .i_lane_write_select_n, .i_output_enable_n, .i_sleep_request, .i_burst_order,
    .i_data, .o_data, .o_data_oe, .o_sleeping);
  pbs_host_model u_pbs_host_model (.i_clock, .i_drive(drive), .i_wdata(wdata),
    .i_dev_data(o_data), .i_dev_oe(o_data_oe), .o_bus(i_data));

  initial begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end

  // c is {cpu strobe, ctrl strobe, global write, qualify, lane selects}, all active low
  task automatic put(input logic [7:0] c, input logic [7:0] a, input logic [35:0] d);
    {i_cpu_addr_strobe_n, i_ctrl_addr_strobe_n, i_all_lanes_write_n,
     i_lane_write_qualify_n, i_lane_write_select_n} = c;
    i_addr = a;
    wdata  = d;
    drive  = (c != 8'hFF);
    @(posedge i_clock);
    #1;
  endtask : put

  task automatic rd(input logic [7:0] a, input logic [35:0] e);
    put(8'h7F, a, '0);
    put(8'hFF, a, '0);
    `CHK("read data", e, o_data)
  endtask : rd

  task automatic wait_sleep(input logic lvl);
    for (int n = 0; n < 20 && o_sleeping !== lvl; n++) begin
      @(posedge i_clock);
      #1;
    end
    `CHK("sleep state", lvl, o_sleeping)
    if (o_sleeping !== lvl) tally_and_finish();
  endtask : wait_sleep

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    failures = 0;
    checked  = 0;
    // reset low, step high, selects active, output enable off, awake, interleaved
    {i_arst_n, i_burst_step_n, i_select_low_first, i_select_high_second,
     i_select_low_third, i_output_enable_n, i_sleep_request, i_burst_order} = 8'h55;
    {i_cpu_addr_strobe_n, i_ctrl_addr_strobe_n, i_all_lanes_write_n,
     i_lane_write_qualify_n, i_lane_write_select_n} = 8'hFF;
    i_addr = '0;
    wdata  = '0;
    drive  = 1'b0;
    repeat (10) @(posedge i_clock);
    #1;
    `CHK("reset oe", 1'b0, o_data_oe)
    i_arst_n = 1'b1;
    // fill address 0 so that idle reads after reset show a known word
    put(8'h9F, 8'h00, '0);
    put(8'hFF, 8'h00, '0);
    put(8'hFF, 8'h00, '0);
    put(8'hFF, 8'h00, '0);
    // ctrl-strobe writes with global, qualified-lane and no-write controls, each read back
    foreach (rows[i]) begin
      put({2'b10, rc[i][5:4], rc[i][3:2], rc[i][1:0]}, rows[i].a, rows[i].d);
      mem_m[rows[i].a] = rows[i].e;
      rd(rows[i].a, rows[i].e);
    end
    // linear then interleaved burst from start 01, selects dropped mid-burst
    for (int m = 0; m < 2; m++) begin
      i_burst_order = m[0];
      repeat (5) put(8'hFF, 8'h00, '0);
      put(8'h7F, 8'h21, '0);
      i_burst_step_n = 1'b0;
      i_select_high_second = 1'b0;
      for (int k = 0; k < 4; k++) begin
        put(8'hFF, 8'h00, '0);
        `CHK("burst", mem_m[m ? 8'h21 ^ 8'(k) : 8'h20 + 8'((k + 1) % 4)], o_data)
      end
      i_burst_step_n = 1'b1;
      i_select_high_second = 1'b1;
    end
    // deselect, then a read stream with output enable low
    i_output_enable_n = 1'b0;
    repeat (6) put(8'hFF, 8'h00, '0);
    i_select_high_second = 1'b0;
    put(8'hBF, 8'h00, '0);
    i_select_high_second = 1'b1;
    for (int k = 0; k < 7; k++) begin
      put(k < 6 ? 8'h7F : 8'hFF, 8'h20 + 8'(k % 4), '0);
      if (k == 1) `CHK("first read oe", 1'b0, o_data_oe)
      if (k > 1) `CHK("stream oe", 1'b1, o_data_oe)
      if (k > 0) `CHK("stream data", mem_m[8'h20 + 8'((k - 1) % 4)], o_data)
    end
    i_select_high_second = 1'b0;
    put(8'hBF, 8'h00, '0);
    `CHK("deselect oe", 1'b0, o_data_oe)
    i_select_high_second = 1'b1;
    i_output_enable_n = 1'b1;
    repeat (6) put(8'hFF, 8'h00, '0);
    // both strobes with global write: the processor strobe only reads
    put(8'h1F, 8'h20, 36'h0_DEAD_BEEF);
    rd(8'h20, mem_m[8'h20]);
    // processor-strobe write: first-edge controls ignored, second edge writes lane 0
    put(8'h5F, 8'h22, 36'h0);
    put(8'hEE, 8'h00, 36'h7_1234_5678);
    mem_m[8'h22] = {mem_m[8'h22][35:9], 9'h078};
    rd(8'h22, mem_m[8'h22]);
    // sleep and wake with contents kept
    i_sleep_request = 1'b1;
    wait_sleep(1'b1);
    i_sleep_request = 1'b0;
    wait_sleep(1'b0);
    repeat (3) put(8'hFF, 8'h00, '0);
    rd(8'h21, mem_m[8'h21]);
    tally_and_finish();
  end
endmodule : pipelined_burst_sram_port_tb_top
